// *** hw/ltf_font_ctrl.sv ***
// text font expansion control: indexed registers and font row control
// assumes i_io_* is a decoded, synchronous single-cycle I/O cycle on the
// extension data port; the index comes from the extension index latch
// Operation
// - expansion enable stretches each text cell to 19 scanlines.
// - method one duplicates cell scanlines 0, 8 and 15 once each.
// - method zero repeats scanline 0 twice and scanline 15 once.
// - method select has no effect while expansion is disabled.
// - full-height cursor covers whole cell, ignoring cursor start and end.
// - software expanded text takes cell timing from the alternate register set.
// - software expanded text acts only in text modes.
// - two-bit font address field extends upper font memory address.
// - in 16/32-bit memory the font address field selects bold font.
// - registers sit at data port 3CF, indexes 92 and 95.
`timescale 1ns/100ps
module ltf_font_ctrl (
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_io_wr,
   input  wire logic        i_io_rd,
   input  wire logic [15:0] i_io_addr,
   input  wire logic [7:0]  i_io_index,
   input  wire logic [7:0]  i_io_wdata,
   input  wire logic        i_text_mode,
   input  wire logic        i_wide_mem,
   input  wire logic        i_row_adv,
   input  wire logic        i_cell_start,
   input  wire logic [3:0]  i_std_cur_start,
   input  wire logic [3:0]  i_std_cur_end,
   input  wire logic [4:0]  i_std_cell_rows,
   input  wire logic [4:0]  i_alt_cell_rows,
   output logic      [7:0]  o_io_rdata,
   output logic             o_io_ack,
   output logic      [3:0]  o_font_row,
   output logic      [1:0]  o_font_addr_ext,
   output logic             o_bold_sel,
   output logic             o_cursor_row,
   output logic             o_cell_end,
   output logic      [4:0]  o_cell_rows,
   output logic             o_alt_timing_sel,
   output logic      [3:0]  o_burst,
   output logic      [3:0]  o_delta
);
   import ltf_pkg::*;

   logic [7:0] font_text_control_reg;
   logic [7:0] circ_buffer_fetch_params_reg;
   logic       hit_font;
   logic       hit_circ;
   logic       sw_exp_act;
   logic       cur_in_span;

   ltf_row_if rif ();

   ////////////////////////////////////////////////////////////////////
   // register decode
   assign hit_font = (i_io_addr == LTF_DATA_PORT) && (i_io_index == LTF_IDX_FONT_CTL);
   assign hit_circ = (i_io_addr == LTF_DATA_PORT) && (i_io_index == LTF_IDX_CIRC_BUF);

   // register writes; reserved bits held at zero
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         font_text_control_reg        <= LTF_FONT_CTL_RST;
         circ_buffer_fetch_params_reg <= LTF_CIRC_BUF_RST;
      end else if (i_io_wr) begin
         if (hit_font)
            font_text_control_reg <= i_io_wdata & LTF_FONT_CTL_WMASK;
         if (hit_circ)
            circ_buffer_fetch_params_reg <= i_io_wdata;
      end
   end

   // read data and acknowledge, one cycle after the request
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_io_rdata <= 8'h00;
         o_io_ack   <= 1'b0;
      end else begin
         o_io_ack   <= (i_io_rd || i_io_wr) && (hit_font || hit_circ);
         o_io_rdata <= (i_io_rd && hit_font) ? font_text_control_reg :
                       (i_io_rd && hit_circ) ? circ_buffer_fetch_params_reg : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // row sequencer
   assign rif.exp_en     = font_text_control_reg[LTF_BIT_EXP_EN] && i_text_mode;
   assign rif.exp_meth   = font_text_control_reg[LTF_BIT_EXP_METH];
   assign rif.row_adv    = i_row_adv;
   assign rif.cell_start = i_cell_start;

   ltf_row_gen u_row_gen (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .rif     (rif)
   );

   assign sw_exp_act  = font_text_control_reg[LTF_BIT_SW_EXP] && i_text_mode;
   assign cur_in_span = (rif.src_row >= i_std_cur_start) && (rif.src_row <= i_std_cur_end);

   ////////////////////////////////////////////////////////////////////
   // registered font and timing outputs
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_font_row       <= 4'h0;
         o_font_addr_ext  <= 2'b00;
         o_bold_sel       <= 1'b0;
         o_cursor_row     <= 1'b0;
         o_cell_end       <= 1'b0;
         o_cell_rows      <= 5'h00;
         o_alt_timing_sel <= 1'b0;
         o_burst          <= 4'h0;
         o_delta          <= 4'h0;
      end else begin
         o_font_row       <= rif.src_row;
         o_font_addr_ext  <= font_text_control_reg[1:0];
         o_bold_sel       <= i_wide_mem && (font_text_control_reg[1:0] != 2'b00);
         o_cursor_row     <= font_text_control_reg[LTF_BIT_FULL_CUR] || cur_in_span;
         o_cell_end       <= rif.cell_end;
         o_alt_timing_sel <= sw_exp_act;
         o_cell_rows      <= sw_exp_act ? i_alt_cell_rows : i_std_cell_rows;
         o_burst          <= circ_buffer_fetch_params_reg[7:4];
         o_delta          <= circ_buffer_fetch_params_reg[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_reserved_zero;
      @(posedge i_clock) disable iff (!i_rst_b)
      font_text_control_reg[4] == 1'b0 && font_text_control_reg[2] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_full_cursor;
      @(posedge i_clock) disable iff (!i_rst_b)
      ##1 $past(font_text_control_reg[LTF_BIT_FULL_CUR]) |-> o_cursor_row;
   endproperty
   a_full_cursor: assert property (p_full_cursor) else $error("cursor not full height");

   property p_gfx_no_alt;
      @(posedge i_clock) disable iff (!i_rst_b)
      !i_text_mode |=> !o_alt_timing_sel;
   endproperty
   a_gfx_no_alt: assert property (p_gfx_no_alt) else $error("alt timing in graphics");

   property p_alt_rows;
      @(posedge i_clock) disable iff (!i_rst_b)
      (font_text_control_reg[LTF_BIT_SW_EXP] && i_text_mode) |=>
         (o_cell_rows == $past(i_alt_cell_rows)) && o_alt_timing_sel;
   endproperty
   a_alt_rows: assert property (p_alt_rows) else $error("alt rows not used");

   property p_read_back;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_io_rd && hit_font) |=> o_io_ack && (o_io_rdata == $past(font_text_control_reg));
   endproperty
   a_read_back: assert property (p_read_back) else $error("bad read of font control");

   property p_addr_ext;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_io_wr && hit_font) |=> ##1 o_font_addr_ext == $past(i_io_wdata[1:0], 2);
   endproperty
   a_addr_ext: assert property (p_addr_ext) else $error("font address not applied");

   property p_bold;
      @(posedge i_clock) disable iff (!i_rst_b)
      !i_wide_mem |=> !o_bold_sel;
   endproperty
   a_bold: assert property (p_bold) else $error("bold outside wide memory");

   property p_bold_on;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_wide_mem && font_text_control_reg[1:0] != 2'b00) |=> o_bold_sel;
   endproperty
   a_bold_on: assert property (p_bold_on) else $error("bold font not selected");

   ////////////////////////////////////////////////////////////////////
   // register bus checks
   property p_write_lands;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_io_wr && hit_font) |=>
         font_text_control_reg == ($past(i_io_wdata) & LTF_FONT_CTL_WMASK);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write lost");

   property p_refused;
      @(posedge i_clock) disable iff (!i_rst_b)
      ((i_io_rd || i_io_wr) && !hit_font && !hit_circ) |=>
         !o_io_ack && (o_io_rdata == 8'h00);
   endproperty
   a_refused: assert property (p_refused) else $error("unmapped cycle answered");

   property p_fetch_fields;
      @(posedge i_clock) disable iff (!i_rst_b)
      1'b1 |=> (o_burst == $past(circ_buffer_fetch_params_reg[7:4])) &&
               (o_delta == $past(circ_buffer_fetch_params_reg[3:0]));
   endproperty
   a_fetch_fields: assert property (p_fetch_fields) else $error("burst or delta wrong");

   ////////////////////////////////////////////////////////////////////
   // font and timing output checks
   property p_expand_text;
      @(posedge i_clock) disable iff (!i_rst_b)
      !i_text_mode |-> !rif.exp_en;
   endproperty
   a_expand_text: assert property (p_expand_text) else $error("expansion in graphics");

   property p_font_row;
      @(posedge i_clock) disable iff (!i_rst_b)
      1'b1 |=> o_font_row == $past(rif.src_row);
   endproperty
   a_font_row: assert property (p_font_row) else $error("font row stale");

   property p_cursor_span;
      @(posedge i_clock) disable iff (!i_rst_b)
      !font_text_control_reg[LTF_BIT_FULL_CUR] |=>
         o_cursor_row == (($past(rif.src_row) >= $past(i_std_cur_start)) &&
                          ($past(rif.src_row) <= $past(i_std_cur_end)));
   endproperty
   a_cursor_span: assert property (p_cursor_span) else $error("cursor outside span");

   property p_std_rows;
      @(posedge i_clock) disable iff (!i_rst_b)
      !(font_text_control_reg[LTF_BIT_SW_EXP] && i_text_mode) |=>
         (o_cell_rows == $past(i_std_cell_rows)) && !o_alt_timing_sel;
   endproperty
   a_std_rows: assert property (p_std_rows) else $error("standard rows not used");

   c_exp_on:  cover property (@(posedge i_clock) rif.exp_en && i_row_adv);
   c_sw_exp:  cover property (@(posedge i_clock) o_alt_timing_sel);
endmodule

// *** hw/ltf_pkg.sv ***
// package for the text font expansion control block
// assumes an indexed register port: index from a separate latch, data at 3CF
package ltf_pkg;
   localparam logic [15:0] LTF_DATA_PORT    = 16'h03CF;
   localparam logic [7:0]  LTF_IDX_FONT_CTL = 8'h92;
   localparam logic [7:0]  LTF_IDX_CIRC_BUF = 8'h95;
   localparam logic [7:0]  LTF_FONT_CTL_RST = 8'h00;
   localparam logic [7:0]  LTF_CIRC_BUF_RST = 8'h00;
   localparam logic [7:0]  LTF_FONT_CTL_WMASK = 8'hEB;
   localparam int LTF_BIT_EXP_EN   = 7;
   localparam int LTF_BIT_EXP_METH = 6;
   localparam int LTF_BIT_FULL_CUR = 5;
   localparam int LTF_BIT_SW_EXP   = 3;
   localparam logic [4:0] LTF_CELL_ROWS    = 5'h10;
   localparam logic [4:0] LTF_EXP_ROWS     = 5'h13;
   localparam logic [3:0] LTF_ROW_FIRST    = 4'h0;
   localparam logic [3:0] LTF_ROW_MID      = 4'h8;
   localparam logic [3:0] LTF_ROW_LAST     = 4'hF;
   typedef enum logic [1:0] {
      LTF_IDLE = 2'b00,
      LTF_ORIG = 2'b01,
      LTF_DUP  = 2'b10
   } ltf_row_e;
endpackage

// *** hw/ltf_row_gen.sv ***
// scanline sequencer mapping display rows of a cell to font source rows
// assumes row_adv pulses once per scanline from the display timing
`timescale 1ns/100ps
module ltf_row_gen (
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   ltf_row_if.gen    rif
);
   import ltf_pkg::*;

   ltf_row_e   state_reg;
   logic [1:0] dup_left_reg;
   logic       dup_now;

   ////////////////////////////////////////////////////////////////////
   // duplicate flag for the row just shown
   always_comb begin
      dup_now = 1'b0;
      if (rif.exp_en) begin
         if (rif.exp_meth)
            dup_now = (rif.src_row == LTF_ROW_FIRST) || (rif.src_row == LTF_ROW_MID) ||
                      (rif.src_row == LTF_ROW_LAST);
         else
            dup_now = (rif.src_row == LTF_ROW_FIRST) || (rif.src_row == LTF_ROW_LAST);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // source row walk, duplicates directly after original
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         state_reg    <= LTF_IDLE;
         rif.src_row  <= 4'h0;
         rif.disp_row <= 5'h00;
         dup_left_reg <= 2'b00;
      end else if (rif.cell_start) begin
         state_reg    <= LTF_ORIG;
         rif.src_row  <= LTF_ROW_FIRST;
         rif.disp_row <= 5'h00;
         dup_left_reg <= 2'b00;
      end else if (rif.row_adv && state_reg != LTF_IDLE) begin
         rif.disp_row <= rif.disp_row + 5'h01;
         if (state_reg == LTF_ORIG && dup_now) begin
            state_reg    <= LTF_DUP;
            dup_left_reg <= (!rif.exp_meth && rif.src_row == LTF_ROW_FIRST) ? 2'b01 : 2'b00;
         end else if (state_reg == LTF_DUP && dup_left_reg != 2'b00) begin
            dup_left_reg <= dup_left_reg - 2'b01;
         end else if (rif.src_row == LTF_ROW_LAST) begin
            state_reg    <= LTF_ORIG;
            rif.src_row  <= LTF_ROW_FIRST;
            rif.disp_row <= 5'h00;
         end else begin
            state_reg   <= LTF_ORIG;
            rif.src_row <= rif.src_row + 4'h1;
         end
      end
   end

   // last row of the cell: 19 rows expanded, 16 plain
   assign rif.cell_end = (rif.disp_row == (rif.exp_en ? LTF_EXP_ROWS - 5'h01
                                                      : LTF_CELL_ROWS - 5'h01));

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_row_bound;
      @(posedge i_clock) disable iff (!i_rst_b)
      rif.exp_en |-> rif.disp_row < LTF_EXP_ROWS;
   endproperty
   a_row_bound: assert property (p_row_bound) else $error("row past 19");

   property p_plain;
      @(posedge i_clock) disable iff (!i_rst_b)
      (!rif.exp_en && rif.row_adv && state_reg == LTF_ORIG && !rif.cell_start) |=>
         state_reg == LTF_ORIG;
   endproperty
   a_plain: assert property (p_plain) else $error("dup while unexpanded");

   property p_dup_follows;
      @(posedge i_clock) disable iff (!i_rst_b)
      (state_reg == LTF_DUP) |-> $stable(rif.src_row);
   endproperty
   a_dup_follows: assert property (p_dup_follows) else $error("dup row moved");

   property p_meth1_mid;
      @(posedge i_clock) disable iff (!i_rst_b)
      (rif.exp_en && rif.exp_meth && rif.row_adv && state_reg == LTF_ORIG &&
       rif.src_row == LTF_ROW_MID && !rif.cell_start) |=> state_reg == LTF_DUP;
   endproperty
   a_meth1_mid: assert property (p_meth1_mid) else $error("row 8 not duplicated");

   property p_meth0_mid;
      @(posedge i_clock) disable iff (!i_rst_b)
      (rif.exp_en && !rif.exp_meth && rif.row_adv && state_reg == LTF_ORIG &&
       rif.src_row == LTF_ROW_MID && !rif.cell_start) |=> state_reg == LTF_ORIG;
   endproperty
   a_meth0_mid: assert property (p_meth0_mid) else $error("row 8 duplicated");

   c_dup:  cover property (@(posedge i_clock) state_reg == LTF_DUP);
   c_wrap: cover property (@(posedge i_clock) rif.exp_en && rif.cell_end);
   c_dbl:  cover property (@(posedge i_clock) state_reg == LTF_DUP && dup_left_reg == 2'b01);
endmodule

// *** hw/ltf_row_if.sv ***
// row sequencing signals between the control top and the row generator
// assumes one clock domain
`timescale 1ns/100ps
interface ltf_row_if;
   logic       exp_en;
   logic       exp_meth;
   logic       row_adv;
   logic       cell_start;
   logic [3:0] src_row;
   logic [4:0] disp_row;
   logic       cell_end;
   modport ctl (output exp_en, exp_meth, row_adv, cell_start,
                input src_row, disp_row, cell_end);
   modport gen (input exp_en, exp_meth, row_adv, cell_start,
                output src_row, disp_row, cell_end);
endinterface

// *** verification/test_ltf_font_ctrl.sv ***
// self-checking bench for the text font expansion control block
// assumes the design package and the row interface are compiled first
`timescale 1ns/100ps
module test_ltf_font_ctrl;
   import ltf_pkg::*;
   typedef struct {
      logic [7:0] ctl;
      logic       text;
      logic       wide;
      logic [7:0] rd;
      logic [1:0] ext;
      logic       bold;
      logic       alt;
   } ltf_tb_row_s;
   logic       i_clock = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       i_io_wr = 1'b0;
   logic       i_io_rd = 1'b0;
   logic [15:0] i_io_addr = 16'h0000;
   logic [7:0] i_io_index = 8'h00;
   logic [7:0] i_io_wdata = 8'h00;
   logic       i_text_mode = 1'b1;
   logic       i_wide_mem = 1'b0;
   logic       i_row_adv = 1'b0;
   logic       i_cell_start = 1'b0;
   logic [3:0] i_std_cur_start = 4'h3;
   logic [3:0] i_std_cur_end = 4'h5;
   logic [4:0] i_std_cell_rows = 5'h10;
   logic [4:0] i_alt_cell_rows = 5'h13;
   logic [7:0] o_io_rdata, q;
   logic       o_io_ack, o_bold_sel, o_cursor_row, o_cell_end, o_alt_timing_sel;
   logic [3:0] o_font_row, o_burst, o_delta;
   logic [1:0] o_font_addr_ext;
   logic [4:0] o_cell_rows;
   int         bad_count = 0;
   int         checks_done = 0;
   ltf_tb_row_s rows [6] = '{
      '{8'hFF, 1'b1, 1'b1, 8'hEB, 2'h3, 1'b1, 1'b1},
      '{8'h08, 1'b0, 1'b0, 8'h08, 2'h0, 1'b0, 1'b0},
      '{8'h08, 1'b1, 1'b0, 8'h08, 2'h0, 1'b0, 1'b1},
      '{8'h02, 1'b0, 1'b1, 8'h02, 2'h2, 1'b1, 1'b0},
      '{8'h01, 1'b0, 1'b0, 8'h01, 2'h1, 1'b0, 1'b0},
      '{8'h14, 1'b1, 1'b1, 8'h00, 2'h0, 1'b0, 1'b0}};
   logic [7:0] modes [5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hA0};

   ltf_font_ctrl u_ltf_font_ctrl (.*);

   ////////////////////////////////////////////////////////////////////////////
   // clock at 20 MHz
   always #25 i_clock = ~i_clock;

   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // one I/O cycle; ack and read data show in the following cycle
   task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] idx,
                     input logic [7:0] d, input logic hit);
      @(negedge i_clock);
      i_io_wr = wr;
      i_io_rd = !wr;
      i_io_addr = a;
      i_io_index = idx;
      i_io_wdata = d;
      @(negedge i_clock);
      i_io_wr = 1'b0;
      i_io_rd = 1'b0;
      q = o_io_rdata;
      chk({7'h00, o_io_ack}, {7'h00, hit});
   endtask

   // expected source scanline of display row k
   function automatic logic [3:0] exp_row(input logic [7:0] c, input int k);
      int r;
      if (!c[7]) r = k;
      else if (c[6]) r = (k < 2) ? 0 : (k <= 9) ? k - 1 : (k == 10) ? 8 : (k <= 17) ? k - 2 : 15;
      else r = (k < 3) ? 0 : (k <= 17) ? k - 2 : 15;
      return r[3:0];
   endfunction

   // walk one full cell plus the wrap, stepping every four cycles
   task automatic walk(input logic [7:0] c);
      logic [3:0] e;
      int n;
      n = c[7] ? 19 : 16;
      io(1'b1, LTF_DATA_PORT, LTF_IDX_FONT_CTL, c, 1'b1);
      i_cell_start = 1'b1;
      @(negedge i_clock);
      i_cell_start = 1'b0;
      repeat (2) @(negedge i_clock);
      for (int k = 0; k <= n; k++) begin
         e = exp_row(c, k % n);
         chk({4'h0, o_font_row}, {4'h0, e});
         chk({7'h00, o_cell_end}, {7'h00, k == n - 1});
         chk({7'h00, o_cursor_row}, {7'h00, c[5] | (e >= 4'h3 && e <= 4'h5)});
         i_row_adv = 1'b1;
         @(negedge i_clock);
         i_row_adv = 1'b0;
         repeat (3) @(negedge i_clock);
      end
      $display("row walk %h done", c);
   endtask

   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the tests take under 1500 cycles
   initial begin
      #250000;
      bad_count++;
      end_of_test();
   end

   // main sequence
   initial begin
      repeat (2) @(negedge i_clock);
      i_rst_b = 1'b1;
      io(1'b0, LTF_DATA_PORT, LTF_IDX_FONT_CTL, 8'h00, 1'b1);
      chk(q, LTF_FONT_CTL_RST);
      io(1'b0, LTF_DATA_PORT, LTF_IDX_CIRC_BUF, 8'h00, 1'b1);
      chk(q, LTF_CIRC_BUF_RST);
      $display("reset values done");
      // table of control values against decoded outputs
      foreach (rows[i]) begin
         i_text_mode = rows[i].text;
         i_wide_mem = rows[i].wide;
         io(1'b1, LTF_DATA_PORT, LTF_IDX_FONT_CTL, rows[i].ctl, 1'b1);
         io(1'b0, LTF_DATA_PORT, LTF_IDX_FONT_CTL, 8'h00, 1'b1);
         chk(q, rows[i].rd);
         chk({6'h00, o_font_addr_ext}, {6'h00, rows[i].ext});
         chk({7'h00, o_bold_sel}, {7'h00, rows[i].bold});
         chk({7'h00, o_alt_timing_sel}, {7'h00, rows[i].alt});
         chk({3'h0, o_cell_rows}, rows[i].alt ? 8'h13 : 8'h10);
         $display("table row %0d done", i);
      end
      i_text_mode = 1'b1;
      i_wide_mem = 1'b0;
      // software expanded text: glyphs come from the host, rows stay plain
      walk(8'h08);
      foreach (modes[i]) walk(modes[i]);
      // refused cycles: wrong port and unmapped index
      io(1'b1, 16'h03CE, LTF_IDX_FONT_CTL, 8'hFF, 1'b0);
      io(1'b0, LTF_DATA_PORT, LTF_IDX_FONT_CTL, 8'h00, 1'b1);
      chk(q, 8'hA0);
      io(1'b0, LTF_DATA_PORT, 8'h93, 8'h00, 1'b0);
      chk(q, 8'h00);
      $display("refused cycles done");
      // burst and delta fields, then a reset in mid-run
      io(1'b1, LTF_DATA_PORT, LTF_IDX_CIRC_BUF, 8'h5A, 1'b1);
      @(negedge i_clock);
      chk({4'h0, o_burst}, 8'h05);
      chk({4'h0, o_delta}, 8'h0A);
      i_rst_b = 1'b0;
      repeat (2) @(negedge i_clock);
      i_rst_b = 1'b1;
      chk({4'h0, o_burst}, 8'h00);
      io(1'b0, LTF_DATA_PORT, LTF_IDX_CIRC_BUF, 8'h00, 1'b1);
      chk(q, 8'h00);
      io(1'b0, LTF_DATA_PORT, LTF_IDX_FONT_CTL, 8'h00, 1'b1);
      chk(q, 8'h00);
      $display("mid-run reset done");
      end_of_test();
   end
endmodule
